// *** sps_buffer.sv ***
// sps_buffer: apb register slave, status flags, rate divider and byte shifter of an spi port.
// assumes pins arrive asynchronously and are resolved to wires by the surroundings.
// Operation
// - byte received sets rx_full, irq if enabled
// - data read clears rx_full; reset clears
// - error_irq_enable gates overrun and mode fault
// - overrun keeps old byte, drops new
// - overrun clears by status then data read
// - slave: select high mid-byte sets mode fault
// - master: select low sets mode fault
// - mode fault clears by status then data write
// - tx handoff to shifter sets tx_empty
// - enabled idle write reloads tx_empty within two cycles
// - busy slave holds tx byte until done
// - reset sets tx_empty
// - mode fault sets only when enabled
// - master without enable ignores select pin
// - slave: enable only suppresses mode fault
// - rate field picks divisor 2/8/32/128
// - serial clock is bus clock over divisor
// - writes fill tx buffer, reads rx buffer
`timescale 1ns/1ns
module sps_buffer
  import sps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sps_pins_in_t pins_in,
  output sps_pins_out_t pins_out,
  output logic ss_is_spi_input,
  output logic irq
);

  function automatic logic [HALF_W-1:0] half_period(input logic [1:0] sel);
    int bd;
    case (sel)
      2'b00: bd = DIV_SEL0;
      2'b01: bd = DIV_SEL1;
      2'b10: bd = DIV_SEL2;
      default: bd = DIV_SEL3;
    endcase
    half_period = HALF_W'(bd / 2 - 1);
  endfunction : half_period

  function automatic logic od_enable(input logic drive, input logic wired, input logic bit_v);
    // wired-or pins only pull low and leave high to the pull-up
    od_enable = drive & (~wired | ~bit_v);
  endfunction : od_enable

  sps_ctrl_t ctrl;
  logic error_irq_enable;
  logic mode_fault_enable;
  logic rate_select_hi;
  logic rate_select_lo;
  logic rx_full_flag;
  logic overrun_flag;
  logic mode_fault_flag;
  logic tx_full;
  logic tx_empty_flag;
  logic overrun_seen;
  logic mode_fault_seen;
  logic [7:0] tx_buf;
  logic [7:0] rx_buf;

  sps_state_t state;
  logic [7:0] shift;
  logic [3:0] edge_cnt;
  logic [HALF_W-1:0] div_cnt;
  logic samp;
  logic sclk_r;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [1:0] m_req;
  logic [2:0] m_fin;
  logic [7:0] m_rx;
  logic rx_done;
  logic [7:0] rx_word;
  sps_pins_in_t sync_a;
  sps_pins_in_t sync_b;
  logic sclk_d;
  logic ss_d;
  logic apb_acc;
  logic [7:0] idx;
  logic hit;
  logic wr_data;
  logic rd_data;
  logic rd_stat;
  logic wr_ctrl;
  logic wr_stat;
  logic [31:0] read_mux;
  logic tick;
  logic sclk_chg;
  logic ev;
  logic in_bit;
  logic tx_load;
  logic slave_start;
  logic mf_set;
  logic [7:0] status_byte;

  // apb decode; zero wait states, so pready follows the access phase
  assign apb_acc = psel & penable;
  assign idx = paddr[ADDR_W-1:2];
  assign hit = (idx == IDX_CTRL) | (idx == IDX_STAT) | (idx == IDX_DATA);
  assign pready = apb_acc;
  assign pslverr = apb_acc & ~hit;
  assign wr_ctrl = apb_acc & pwrite & (idx == IDX_CTRL);
  assign wr_stat = apb_acc & pwrite & (idx == IDX_STAT);
  assign wr_data = apb_acc & pwrite & (idx == IDX_DATA);
  assign rd_data = apb_acc & ~pwrite & (idx == IDX_DATA);
  assign rd_stat = apb_acc & ~pwrite & (idx == IDX_STAT);

  assign tx_empty_flag = ~tx_full;
  assign status_byte = {rx_full_flag, error_irq_enable, overrun_flag, mode_fault_flag,
                        tx_empty_flag, mode_fault_enable, rate_select_hi, rate_select_lo};

  always_comb begin
    case (idx)
      IDX_CTRL: read_mux = {24'h00_0000, ctrl};
      IDX_STAT: read_mux = {24'h00_0000, status_byte};
      IDX_DATA: read_mux = {24'h00_0000, rx_buf};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup phase, so the access edge sees a steady word
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= read_mux;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl <= CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[7:0] & CTL_WMASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      error_irq_enable <= STS_RESET[STS_ERR_IRQ_EN];
      mode_fault_enable <= STS_RESET[STS_MF_ENABLE];
      rate_select_hi <= STS_RESET[STS_RATE_HI];
      rate_select_lo <= STS_RESET[STS_RATE_LO];
    end else if (wr_stat) begin
      error_irq_enable <= pwdata[STS_ERR_IRQ_EN];
      mode_fault_enable <= pwdata[STS_MF_ENABLE];
      rate_select_hi <= pwdata[STS_RATE_HI];
      rate_select_lo <= pwdata[STS_RATE_LO];
    end
  end

  // two-stage synchronisers on every pin input
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync_a <= PINS_IDLE;
      sync_b <= PINS_IDLE;
      sclk_d <= 1'b0;
      ss_d <= 1'b1;
    end else begin
      sync_a <= pins_in;
      sync_b <= sync_a;
      sclk_d <= sync_b.sclk;
      ss_d <= sync_b.ss_n;
    end
  end

  // select pin is only the port's own input where it can raise a fault or frame a slave
  assign ss_is_spi_input = ctrl.enable & (~ctrl.master | mode_fault_enable);

  assign tick = (state == SPS_MRUN) && (div_cnt == half_period({rate_select_hi,
                                                                rate_select_lo}));
  assign sclk_chg = sync_b.sclk ^ sclk_d;
  assign ev = tick | ((state == SPS_SRUN) & sclk_chg & ~sync_b.ss_n);
  assign in_bit = ctrl.master ? sync_b.miso : sync_b.mosi;
  // an active slave keeps the buffered byte until its frame is over
  assign tx_load = (state == SPS_IDLE) & tx_full & ctrl.enable;
  assign slave_start = (state == SPS_IDLE) & ctrl.enable & ~ctrl.master & ~sync_b.ss_n &
                       (ctrl.cpha ? sclk_chg : ss_d);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_cnt <= '0;
    end else if (state != SPS_MRUN || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  // master reads miso two cycles late, after the synchroniser; far side holds it until then
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      m_req <= 2'b00;
      m_fin <= 3'b000;
      m_rx <= 8'h00;
    end else begin
      m_req <= {m_req[0], tick & ctrl.enable & (edge_cnt[0] == ctrl.cpha)};
      m_fin <= {m_fin[1:0], tick & ctrl.enable & (edge_cnt == LAST_EDGE)};
      if (m_req[1]) begin
        m_rx <= {m_rx[6:0], sync_b.miso};
      end
    end
  end
  assign rx_done = byte_done | m_fin[2];
  assign rx_word = ctrl.master ? m_rx : rx_byte;
  // shared byte engine: edges come from the divider as master, from the pin as slave
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= SPS_IDLE;
      shift <= 8'h00;
      edge_cnt <= 4'h0;
      samp <= 1'b0;
      sclk_r <= 1'b0;
      byte_done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      byte_done <= 1'b0;
      case (state)
        SPS_IDLE: begin
          sclk_r <= ctrl.cpol;
          edge_cnt <= 4'h0;
          if (tx_load) begin
            shift <= tx_buf;
          end
          if (ctrl.enable && ctrl.master && tx_load) begin
            state <= SPS_MRUN;
          end else if (slave_start) begin
            state <= SPS_SRUN;
            edge_cnt <= ctrl.cpha ? 4'h1 : 4'h0;
          end
        end
        SPS_MRUN, SPS_SRUN: begin
          if (!ctrl.enable || (state == SPS_SRUN && sync_b.ss_n)) begin
            state <= SPS_IDLE;
          end else if (ev) begin
            if (state == SPS_MRUN) begin
              sclk_r <= ~sclk_r;
            end
            edge_cnt <= edge_cnt + 1'b1;
            if (edge_cnt == LAST_EDGE) begin
              byte_done <= (state == SPS_SRUN);
              rx_byte <= {shift[6:0], ctrl.cpha ? in_bit : samp};
              state <= SPS_IDLE;
            end else if (edge_cnt[0] == ctrl.cpha) begin
              samp <= in_bit;
            end else if (edge_cnt != 4'h0) begin
              shift <= {shift[6:0], samp};
            end
          end
        end
        default: state <= SPS_IDLE;
      endcase
    end
  end

  always_comb begin
    pins_out.sclk_o = sclk_r;
    pins_out.sclk_oe = od_enable(ctrl.enable & ctrl.master, ctrl.wired_or, sclk_r);
    pins_out.mosi_o = shift[7];
    pins_out.mosi_oe = od_enable(ctrl.enable & ctrl.master, ctrl.wired_or, shift[7]);
    pins_out.miso_o = shift[7];
    pins_out.miso_oe = od_enable(ctrl.enable & ~ctrl.master & ~sync_b.ss_n, ctrl.wired_or,
                                 shift[7]);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_full <= 1'b0;
      tx_buf <= 8'h00;
    end else begin
      tx_full <= wr_data | (tx_full & ~tx_load);
      if (wr_data) begin
        tx_buf <= pwdata[7:0];
      end
    end
  end
  // receive side: a data read clears rx_full even when a byte lands in the same cycle; overrun's set beats its clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_full_flag <= 1'b0;
      rx_buf <= 8'h00;
    end else begin
      rx_full_flag <= (rx_done & ~rx_full_flag) | (rx_full_flag & ~rd_data);
      if (rx_done && !rx_full_flag) begin
        rx_buf <= rx_word;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      overrun_flag <= 1'b0;
      overrun_seen <= 1'b0;
    end else begin
      overrun_flag <= (rx_done & rx_full_flag) |
                      (overrun_flag & ~(rd_data & overrun_seen));
      if (rd_stat) begin
        overrun_seen <= overrun_flag;
      end else if (rd_data) begin
        overrun_seen <= 1'b0;
      end
    end
  end

  assign mf_set = mode_fault_enable & ctrl.enable &
                  (ctrl.master ? ~sync_b.ss_n : ((state == SPS_SRUN) & sync_b.ss_n));

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_fault_flag <= 1'b0;
      mode_fault_seen <= 1'b0;
    end else begin
      mode_fault_flag <= mf_set | (mode_fault_flag & ~(wr_data & mode_fault_seen));
      if (rd_stat) begin
        mode_fault_seen <= mode_fault_flag;
      end else if (wr_data) begin
        mode_fault_seen <= 1'b0;
      end
    end
  end

  assign irq = (rx_full_flag & ctrl.rx_irq_enable) | (tx_empty_flag & ctrl.tx_irq_enable) |
               (error_irq_enable & (overrun_flag | mode_fault_flag));
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_status_seen_ovr;
    rd_stat && overrun_flag;
  endsequence
  property p_rx_set;
    rx_done && !rx_full_flag |=> rx_full_flag && rx_buf == $past(rx_word);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx byte not stored");
  property p_rx_clr;
    rd_data && !rx_done |=> !rx_full_flag;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("data read left rx_full");
  property p_err_gate;
    !error_irq_enable && !(rx_full_flag && ctrl.rx_irq_enable) &&
      !(tx_empty_flag && ctrl.tx_irq_enable) |-> !irq;
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error irq not gated");
  property p_overrun;
    rx_done && rx_full_flag |=> overrun_flag && $stable(rx_buf);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun mishandled");
  // apb puts at least two cycles between the status access and the data access
  property p_ovr_clear;
    s_status_seen_ovr ##[2:3] (rd_data && !rx_done) |=> !overrun_flag;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");
  property p_ovr_hold;
    $fell(overrun_flag) |-> $past(rd_data);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared early");

  property p_master_mf;
    ctrl.enable && ctrl.master && mode_fault_enable && !sync_b.ss_n |=> mode_fault_flag;
  endproperty
  a_master_mf: assert property (p_master_mf) else $error("master fault missed");

  property p_mf_clear;
    $fell(mode_fault_flag) |-> $past(wr_data) && $past(mode_fault_seen);
  endproperty
  a_mf_clear: assert property (p_mf_clear) else $error("mode fault cleared early");

  property p_mf_enable;
    !mode_fault_enable && !mode_fault_flag |=> !mode_fault_flag;
  endproperty
  a_mf_enable: assert property (p_mf_enable) else $error("fault set while off");

  property p_tx_reload;
    wr_data && state == SPS_IDLE && ctrl.enable && ctrl.master && !tx_full
      |-> ##[1:2] tx_empty_flag;
  endproperty
  a_tx_reload: assert property (p_tx_reload) else $error("tx_empty late");

  property p_slave_hold;
    state == SPS_SRUN && tx_full |=> tx_full;
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("busy slave took byte");

  property p_rate;
    tick |-> $past(div_cnt) == half_period({rate_select_hi, rate_select_lo}) - 1'b1 ||
      half_period({rate_select_hi, rate_select_lo}) == '0;
  endproperty
  a_rate: assert property (p_rate) else $error("divider half period wrong");

endmodule : sps_buffer

// *** sps_pkg.sv ***
// sps_pkg: constants, register map and pin carriers of the spi status and data buffer.
// assumes a 32-bit apb bus with word-aligned registers on a 25 MHz bus clock.
package sps_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h10;
  localparam logic [7:0] IDX_STAT = 8'h11;
  localparam logic [7:0] IDX_DATA = 8'h12;
  localparam int ADDR_W = 10;

  // control register fields (serial control)
  localparam int CTL_RX_IRQ_EN = 7;
  localparam int CTL_MASTER = 5;
  localparam int CTL_CPOL = 4;
  localparam int CTL_CPHA = 3;
  localparam int CTL_WIRED_OR = 2;
  localparam int CTL_ENABLE = 1;
  localparam int CTL_TX_IRQ_EN = 0;
  localparam logic [7:0] CTL_WMASK = 8'hBF;
  localparam logic [7:0] CTL_RESET = 8'h28;

  // serial_status_control fields
  localparam int STS_RX_FULL = 7;
  localparam int STS_ERR_IRQ_EN = 6;
  localparam int STS_OVERRUN = 5;
  localparam int STS_MODE_FAULT = 4;
  localparam int STS_TX_EMPTY = 3;
  localparam int STS_MF_ENABLE = 2;
  localparam int STS_RATE_HI = 1;
  localparam int STS_RATE_LO = 0;
  localparam logic [7:0] STS_RESET = 8'h08;

  // bus clock and transmit-empty recovery time
  localparam int CLK_PERIOD_NS = 40;
  localparam int TX_EMPTY_MAX_NS = 80;
  localparam int TX_EMPTY_MAX_CYC = TX_EMPTY_MAX_NS / CLK_PERIOD_NS;

  // rate divisors for rate_select_hi:rate_select_lo
  localparam int DIV_SEL0 = 2;
  localparam int DIV_SEL1 = 8;
  localparam int DIV_SEL2 = 32;
  localparam int DIV_SEL3 = 128;
  localparam int HALF_W = 6;
  localparam logic [3:0] LAST_EDGE = 4'hF;

  typedef enum logic [1:0] {
    SPS_IDLE = 2'b00,
    SPS_MRUN = 2'b01,
    SPS_SRUN = 2'b11
  } sps_state_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } sps_pins_in_t;

  localparam sps_pins_in_t PINS_IDLE = 4'h1;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } sps_pins_out_t;

  typedef struct packed {
    logic rx_irq_enable;
    logic rsvd;
    logic master;
    logic cpol;
    logic cpha;
    logic wired_or;
    logic enable;
    logic tx_irq_enable;
  } sps_ctrl_t;

endpackage : sps_pkg

// *** sps_spi_peer.sv ***
// sps_spi_peer: behavioural far-side spi device, slave or master, clock phase 1, idle-low clock.
// assumes the bench resolves each pin from all drivers and pulls released lines high.
`timescale 1ns/1ns
module sps_spi_peer (
  input wire logic ref_clk,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sel_n,
  input wire logic [7:0] tx_byte,
  output logic miso_o,
  output logic miso_oe,
  output logic m_sclk,
  output logic m_oe,
  output logic m_mosi,
  output logic m_ss_n,
  output logic [7:0] rx_byte
);
  logic [3:0] edges;
  logic [7:0] sh;
  // released output lets the pull-up win, so a stale bit never reads as data
  assign miso_oe = ~sel_n;
  initial begin
    edges = 4'h0;
    sh = 8'h00;
    miso_o = 1'h0;
    m_sclk = 1'h0;
    m_oe = 1'h0;
    m_mosi = 1'h0;
    m_ss_n = 1'h1;
    rx_byte = 8'h00;
  end
  always @(negedge sel_n) begin
    edges = 4'h0;
  end
  // slave role: leading edge launches msb first, trailing edge samples
  always @(sclk) begin
    if (!sel_n && !m_oe) begin
      if (edges == 4'h0) begin
        sh = tx_byte;
      end
      if (!edges[0]) begin
        miso_o <= sh[3'h7 - edges[3:1]];
      end else begin
        rx_byte <= {rx_byte[6:0], mosi};
      end
      edges = edges + 4'h1;
    end
  end
  // master role: clock is driven low before select falls so no stray edge is seen
  task automatic xfer(input logic [7:0] b, input int nbits, input int half);
    m_oe <= 1'h1;
    m_sclk <= 1'h0;
    repeat (half) @(posedge ref_clk);
    m_ss_n <= 1'h0;
    repeat (half) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      m_sclk <= 1'h1;
      m_mosi <= b[7 - i];
      repeat (half) @(posedge ref_clk);
      m_sclk <= 1'h0;
      rx_byte <= {rx_byte[6:0], miso};
      repeat (half) @(posedge ref_clk);
    end
    m_ss_n <= 1'h1;
    repeat (half) @(posedge ref_clk);
    m_oe <= 1'h0;
  endtask : xfer
endmodule : sps_spi_peer

// *** sps_tb.sv ***
// testbench: drives sps_buffer over apb and its pins against the behavioural spi peer.
// assumes zero-wait apb and peer timing in clock phase 1 with idle-low clock.
`timescale 1ns/1ns
module testbench
  import sps_pkg::*;
;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, ss_is_spi_input, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  sps_pins_in_t pins_in;
  sps_pins_out_t pins_out;
  logic tb_ss_n, peer_sel_n, p_miso, p_oe, m_sclk, m_oe, m_mosi, m_ss_n;
  logic [7:0] peer_tx, peer_rx;
  logic [32:0] exp_q[$];
  logic [32:0] got_q[$];
  int bad_count, n_tests;
  int bd[4] = '{2, 8, 32, 128};
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  assign pins_in = {pins_out.sclk_oe ? pins_out.sclk_o : (m_oe ? m_sclk : 1'h1),
    pins_out.mosi_oe ? pins_out.mosi_o : (m_oe ? m_mosi : 1'h1),
    pins_out.miso_oe ? pins_out.miso_o : (p_oe ? p_miso : 1'h1), tb_ss_n & m_ss_n};
  sps_buffer dut_u (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out),
    .ss_is_spi_input(ss_is_spi_input), .irq(irq));
  sps_spi_peer peer_u (.ref_clk(ref_clk), .sclk(pins_in.sclk), .mosi(pins_in.mosi),
    .miso(pins_in.miso), .sel_n(peer_sel_n), .tx_byte(peer_tx), .miso_o(p_miso),
    .miso_oe(p_oe), .m_sclk(m_sclk), .m_oe(m_oe), .m_mosi(m_mosi), .m_ss_n(m_ss_n),
    .rx_byte(peer_rx));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // watcher: each result is judged against the oldest note
  always @(posedge ref_clk) begin
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      n_tests++;
      if (got_q[0] !== exp_q[0]) begin
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got_q[0], exp_q[0]);
        bad_count++;
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  task automatic note(input logic [32:0] e, input logic [32:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask : note
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [32:0] res);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h00_0000, wd};
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      $display("CHECK FAILED at %0t: no pready", $time);
      bad_count++;
      test_done();
    end
    res = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [32:0] r;
    apb(1'h1, idx, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
    logic [32:0] r;
    apb(1'h0, idx, 8'h00, r);
    note({25'h0, e & m}, {r[32:8], r[7:0] & m});
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_n
  task automatic pick;
    peer_sel_n <= 1'h1;
    wait_n(2);
    peer_sel_n <= 1'h0;
    wait_n(2);
  endtask : pick
  task automatic ss_pulse;
    tb_ss_n <= 1'h0;
    wait_n(6);
    tb_ss_n <= 1'h1;
    wait_n(6);
  endtask : ss_pulse
  // cycles between two serial clock toggles seen at the pin
  task automatic half_cycles(output int n);
    logic s;
    s = pins_out.sclk_o;
    n = 0;
    while (pins_out.sclk_o === s && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    s = pins_out.sclk_o;
    n = 0;
    while (pins_out.sclk_o === s && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : half_cycles
  initial begin
    wait_n(60000);
    $display("CHECK FAILED at %0t: run timed out", $time);
    bad_count++;
    test_done();
  end
  initial begin
    logic [32:0] r;
    logic [7:0] a, b, c;
    int h;
    {psel, penable, pwrite, nrst} = 4'h0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    {tb_ss_n, peer_sel_n} = 2'h3;
    peer_tx = 8'h00;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(32'h45e9_011c));
    wait_n(10);
    nrst <= 1'h1;
    wait_n(1);
    rd(IDX_STAT, STS_RESET, 8'hFF);
    rd(IDX_CTRL, CTL_RESET, 8'hFF);
    note(33'h0, {32'h0, irq});
    apb(1'h0, 8'h13, 8'h00, r);
    note({1'h1, 32'h0}, r);
    wr(IDX_STAT, 8'hFF);
    rd(IDX_STAT, 8'h4F, 8'hFF);
    $display("test reset_and_map done");
    wr(IDX_CTRL, 8'hAA);
    for (int rs = 0; rs < 4; rs++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      peer_tx <= b;
      wr(IDX_STAT, 8'(rs));
      pick();
      wr(IDX_DATA, a);
      rd(IDX_STAT, 8'h08 | 8'(rs), 8'hFF);
      half_cycles(h);
      note(33'(bd[rs] / 2), 33'(h));
      wait_n(8 * bd[rs] + 8);
      rd(IDX_STAT, 8'h88 | 8'(rs), 8'hFF);
      note(33'h1, {32'h0, irq});
      rd(IDX_DATA, b, 8'hFF);
      note({25'h0, a}, {25'h0, peer_rx});
      rd(IDX_STAT, 8'h08 | 8'(rs), 8'hFF);
      note(33'h0, {32'h0, irq});
    end
    $display("test master_rates done");
    wr(IDX_CTRL, 8'h2A);
    wr(IDX_STAT, 8'h00);
    a = 8'($urandom);
    peer_tx <= a;
    pick();
    wr(IDX_DATA, a);
    wr(IDX_DATA, ~a);
    peer_tx <= ~a;
    rd(IDX_STAT, 8'h00, 8'h08);
    wait_n(48);
    rd(IDX_DATA, a, 8'hFF);
    rd(IDX_STAT, 8'h28, 8'hFF);
    note(33'h0, {32'h0, irq});
    wr(IDX_STAT, 8'h40);
    note(33'h1, {32'h0, irq});
    rd(IDX_STAT, 8'h68, 8'hFF);
    rd(IDX_DATA, a, 8'hFF);
    rd(IDX_STAT, 8'h48, 8'hFF);
    note(33'h0, {32'h0, irq});
    $display("test overrun done");
    wr(IDX_STAT, 8'h00);
    note(33'h0, {32'h0, ss_is_spi_input});
    ss_pulse();
    rd(IDX_STAT, 8'h08, 8'hFF);
    wr(IDX_STAT, 8'h44);
    note(33'h1, {32'h0, ss_is_spi_input});
    ss_pulse();
    note(33'h1, {32'h0, irq});
    wr(IDX_STAT, 8'h40);
    wr(IDX_DATA, 8'h5A);
    wait_n(24);
    rd(IDX_STAT, 8'h58, 8'h58);
    wr(IDX_DATA, 8'h5A);
    wait_n(24);
    rd(IDX_STAT, 8'h48, 8'h58);
    nrst <= 1'h0;
    wait_n(3);
    nrst <= 1'h1;
    wait_n(1);
    rd(IDX_STAT, STS_RESET, 8'hFF);
    $display("test mode_fault_master done");
    peer_sel_n <= 1'h1;
    wr(IDX_CTRL, 8'h0B);
    wr(IDX_STAT, 8'h07);
    note(33'h1, {32'h0, ss_is_spi_input});
    a = 8'($urandom);
    b = 8'($urandom);
    c = 8'($urandom);
    wr(IDX_DATA, a);
    rd(IDX_STAT, 8'h0F, 8'hFF);
    note(33'h1, {32'h0, irq});
    fork
      peer_u.xfer(b, 8, 8);
    join_none
    wait_n(40);
    wr(IDX_DATA, c);
    rd(IDX_STAT, 8'h07, 8'hFF);
    note(33'h0, {32'h0, irq});
    wait fork;
    wait_n(6);
    rd(IDX_STAT, 8'h8F, 8'hFF);
    rd(IDX_DATA, b, 8'hFF);
    note({25'h0, a}, {25'h0, peer_rx});
    peer_u.xfer(b, 3, 8);
    wait_n(6);
    rd(IDX_STAT, 8'h10, 8'h10);
    $display("test slave done");
    wait_n(3);
    test_done();
  end
endmodule : testbench
